/* File: logic/wdu_pkg.sv */
// Contract
// - Dog counter advances on the separate 1 MHz oscillator, not the system clock.
// - The kick instruction clears the dog counter and starts a new period.
// - Counter also clears while disabled and on any chip reset.
// - Timeout while enabled without a kick resets the chip.
// - Control register bits 7..5 always read as zero.
// - Hardware clears change-unlock four system clock cycles after it is set.
// - Writing enable one enables; clearing enable works only with change-unlock set.
// - Timeout select picks 16,384 oscillator cycles doubled per step up to 2,097,152.
// - Safety level one: comes up disabled; a single enable write enables it.
// - Level one changes need unlock write, then enable/select write within four cycles.
// - Safety level two: always enabled; enable bit always reads as one.
// - Level two: unlock write, then select write within four cycles; enable ignored.
// - Timeout gives a one system clock internal reset pulse.
// - Timeout sets dog reset flag bit 3; power-on reset or writing zero clears it.
package wdu_pkg;

	// Byte addresses of the Avalon word registers
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_CAUSE = 4'h4;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;

	// Control register fields
	localparam int CTRL_UNLOCK_BIT = 4;
	localparam int CTRL_ENABLE_BIT = 3;
	localparam int CTRL_SEL_LSB = 0;
	localparam int SEL_WIDTH = 3;
	localparam logic [SEL_WIDTH-1:0] SEL_RESET = 3'h0;

	// Reset cause register field
	localparam int CAUSE_DOG_BIT = 3;

	// Interrupt status bits
	localparam int IRQ_TIMEOUT_BIT = 0;
	localparam int IRQ_KICK_BIT = 1;
	localparam int IRQ_WIDTH = 2;

	// Timing
	localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
	localparam int OSC_FREQ_MHZ = 1;
	localparam int BASE_OSC_CYCLES = 16384;
	localparam int CNT_WIDTH = 22;

	typedef struct packed {
		logic enable;
		logic [SEL_WIDTH-1:0] sel;
	} wdu_ctrl_t;

	typedef struct packed {
		logic [3:0] address;
		logic read;
		logic write;
		logic [31:0] writeData;
		logic [3:0] byteEnable;
	} wdu_avreq_t;

endpackage : wdu_pkg

/* File: logic/wdu_sync3.sv */
`timescale 1ns/1ps
module wdu_sync3 #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_r;
	logic [WIDTH-1:0] stage2_r;
	logic [WIDTH-1:0] stage3_r;

	// Three stages; a change counts once stages two and three agree
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					stage1_r[i] <= 1'b0;
					stage2_r[i] <= 1'b0;
					stage3_r[i] <= 1'b0;
					syncOut[i] <= 1'b0;
				end else begin
					stage1_r[i] <= asyncIn[i];
					stage2_r[i] <= stage1_r[i];
					stage3_r[i] <= stage2_r[i];
					if (stage2_r[i] == stage3_r[i]) begin
						syncOut[i] <= stage3_r[i];
					end
				end
			end
		end
	endgenerate

endmodule : wdu_sync3

/* File: logic/wdu_dog_counter.sv */
`timescale 1ns/1ps
module wdu_dog_counter #(
	parameter int BASE_CYCLES = wdu_pkg::BASE_OSC_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic oscTick,
	input wire logic clear,
	input wire logic running,
	input wire logic [wdu_pkg::SEL_WIDTH-1:0] sel,
	output logic expire,
	output logic [wdu_pkg::CNT_WIDTH-1:0] count
);

	logic [wdu_pkg::CNT_WIDTH-1:0] limit;
	logic [wdu_pkg::CNT_WIDTH-1:0] count_r;

	// Limit doubles with each select step; 22 bits hold the largest
	assign limit = wdu_pkg::CNT_WIDTH'((BASE_CYCLES << sel) - 1);
	assign expire = running && oscTick && !clear && (count_r == limit);
	assign count = count_r;

	// Count only oscillator ticks, never system clocks
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			count_r <= '0;
		end else if (clear || !running || expire) begin
			count_r <= '0;
		end else if (oscTick) begin
			count_r <= count_r + 1'b1;
		end
	end

endmodule : wdu_dog_counter

/* File: logic/wdu_top.sv */
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module wdu_top #(
	parameter int BASE_CYCLES = wdu_pkg::BASE_OSC_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic oscClk,
	input wire logic alwaysOnFuse,
	input wire logic kickInstr,
	input wire logic chipReset,
	input wire logic [3:0] avAddress,
	input wire logic avRead,
	input wire logic avWrite,
	input wire logic [31:0] avWriteData,
	input wire logic [3:0] avByteEnable,
	output logic [31:0] avReadData,
	output logic avWaitRequest,
	output logic dogResetPulse,
	output logic irq
);

	// Bus request and stored control
	wdu_pkg::wdu_avreq_t req;
	wdu_pkg::wdu_ctrl_t ctrl_r;

	// Pins from outside the system clock domain
	logic [1:0] syncIn;
	logic [1:0] syncOut;
	logic oscLevel;
	logic oscPrev_r;
	logic oscTick;
	logic levelTwo;

	// Dog state
	logic running;
	logic expire;
	logic dogClear;
	logic [wdu_pkg::CNT_WIDTH-1:0] unusedCount;

	// Bus handshake
	logic ack_r;
	logic wrAccept;
	logic rdAccept;

	// Register write decode
	logic ctrlWrite;
	logic causeClear;
	logic maskWrite;
	logic wrUnlock;
	logic wrEnable;
	logic [wdu_pkg::SEL_WIDTH-1:0] wrSel;

	// Unlock window and reset cause
	logic [2:0] window_r;
	logic windowOpen;
	logic dogFlag_r;

	// Interrupts
	logic [wdu_pkg::IRQ_WIDTH-1:0] irqStatus_r;
	logic [wdu_pkg::IRQ_WIDTH-1:0] irqMask_r;
	logic [wdu_pkg::IRQ_WIDTH-1:0] irqEvents;

	// Read path
	logic [7:0] ctrlView;
	logic [31:0] causeView;
	logic [31:0] statusView;
	logic [31:0] maskView;
	logic [31:0] readMux;

	// Group the bus request
	// One struct, so every decode below reads the same copy
	assign req.address = avAddress;
	assign req.read = avRead;
	assign req.write = avWrite;
	assign req.writeData = avWriteData;
	assign req.byteEnable = avByteEnable;

	// Oscillator and fuse arrive from outside the system clock domain
	// Fuse is not latched: a change takes effect a few cycles later
	assign syncIn = {alwaysOnFuse, oscClk};
	wdu_sync3 #(
		.WIDTH(2)
	) u_sync (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.asyncIn(syncIn),
		.syncOut(syncOut)
	);
	assign oscLevel = syncOut[0];
	assign levelTwo = syncOut[1];

	// Rising edge of the filtered oscillator is one dog tick
	// Previous level resets to the idle level, so no false tick after reset
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			oscPrev_r <= 1'b0;
		end else begin
			oscPrev_r <= oscLevel;
		end
	end
	assign oscTick = oscLevel && !oscPrev_r;

	// Level two forces the dog on regardless of the stored enable
	// Stored enable is not forced; unlock or enable writes made in level two still set it to one
	assign running = levelTwo || ctrl_r.enable;

	// Kick and chip reset both restart the period; clear beats a same-cycle expiry
	assign dogClear = kickInstr || chipReset;

	wdu_dog_counter #(
		.BASE_CYCLES(BASE_CYCLES)
	) u_counter (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.oscTick(oscTick),
		.clear(dogClear),
		.running(running),
		.sel(ctrl_r.sel),
		.expire(expire),
		.count(unusedCount)
	);

	// Bus slave: one wait cycle, then the answer at the next edge
	// Fixed latency keeps the slave simple at the cost of one wait per access
	assign avWaitRequest = (req.read || req.write) && !ack_r;
	assign wrAccept = req.write && ack_r;
	assign rdAccept = req.read && ack_r;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (req.read || req.write) && !ack_r;
		end
	end

	// Control write decode; only the low byte lane holds the register
	// Writes count only at the answer edge, never in the wait cycle
	assign ctrlWrite = wrAccept && req.byteEnable[0] && (req.address == wdu_pkg::ADDR_CONTROL);
	assign wrUnlock = req.writeData[wdu_pkg::CTRL_UNLOCK_BIT];
	assign wrEnable = req.writeData[wdu_pkg::CTRL_ENABLE_BIT];
	assign wrSel = req.writeData[wdu_pkg::CTRL_SEL_LSB +: wdu_pkg::SEL_WIDTH];
	assign windowOpen = (window_r != 3'h0);
	assign causeClear = wrAccept && req.byteEnable[0] && (req.address == wdu_pkg::ADDR_CAUSE)
		&& !req.writeData[wdu_pkg::CAUSE_DOG_BIT];
	assign maskWrite = wrAccept && req.byteEnable[0] && (req.address == wdu_pkg::ADDR_IRQ_MASK);

	// Unlock window: opened by unlock plus enable, self-closing
	// A second unlock write reopens the full window
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			window_r <= 3'h0;
		end else if (chipReset || expire) begin
			window_r <= 3'h0;
		end else if (ctrlWrite && wrUnlock && wrEnable) begin
			window_r <= wdu_pkg::UNLOCK_CYCLES;
		end else if (ctrlWrite && windowOpen) begin
			window_r <= 3'h0;
		end else if (windowOpen) begin
			window_r <= window_r - 3'h1;
		end
	end

	// Enable and timeout select; protected fields change only in the window
	// Timeout clears control as a chip reset would
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r.enable <= 1'b0;
			ctrl_r.sel <= wdu_pkg::SEL_RESET;
		end else if (chipReset || expire) begin
			ctrl_r.enable <= 1'b0;
			ctrl_r.sel <= wdu_pkg::SEL_RESET;
		end else if (ctrlWrite) begin
			if (wrUnlock && wrEnable) begin
				ctrl_r.enable <= 1'b1;
			end else if (windowOpen && !wrUnlock) begin
				// Level two ignores the enable value written here
				ctrl_r.enable <= levelTwo ? ctrl_r.enable : wrEnable;
				ctrl_r.sel <= wrSel;
			end else if (wrEnable) begin
				ctrl_r.enable <= 1'b1;
			end
		end
	end

	// One system clock reset pulse per timeout
	// Registered so the pulse is clean, one cycle after expiry
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			dogResetPulse <= 1'b0;
		end else begin
			dogResetPulse <= expire;
		end
	end

	// Reset cause flag survives chip resets; power-on clears it
	// Software may also clear it by writing zero to the flag
	// Set wins over a clear in the same cycle, so no timeout is lost
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			dogFlag_r <= 1'b0;
		end else if (expire) begin
			dogFlag_r <= 1'b1;
		end else if (causeClear) begin
			dogFlag_r <= 1'b0;
		end
	end

	// Sticky events; a read clears, but a new event in that cycle wins
	assign irqEvents[wdu_pkg::IRQ_TIMEOUT_BIT] = expire;
	assign irqEvents[wdu_pkg::IRQ_KICK_BIT] = kickInstr;

	// One sticky bit per event source
	// Status read clears at the answer edge
	genvar b;

	generate
		for (b = 0; b < wdu_pkg::IRQ_WIDTH; b++) begin : g_irq
			always_ff @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					irqStatus_r[b] <= 1'b0;
				end else if (irqEvents[b]) begin
					irqStatus_r[b] <= 1'b1;
				end else if (rdAccept && (req.address == wdu_pkg::ADDR_IRQ_STATUS)) begin
					irqStatus_r[b] <= 1'b0;
				end
			end
		end
	endgenerate

	// Interrupt mask
	// All sources masked after reset, so no interrupt before software asks
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irqMask_r <= '0;
		end else if (maskWrite) begin
			irqMask_r <= req.writeData[wdu_pkg::IRQ_WIDTH-1:0];
		end
	end

	// Level interrupt from any unmasked sticky bit
	// Registered, so it lags the status by one cycle
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irqStatus_r & irqMask_r);
		end
	end

	// Control view: reserved bits zero, enable forced in level two
	// Unlock bit shows the window, so software can see it close
	always_comb begin
		ctrlView = 8'h00;
		ctrlView[wdu_pkg::CTRL_UNLOCK_BIT] = windowOpen;
		ctrlView[wdu_pkg::CTRL_ENABLE_BIT] = running;
		ctrlView[wdu_pkg::CTRL_SEL_LSB +: wdu_pkg::SEL_WIDTH] = ctrl_r.sel;
	end

	// Word views of the narrow registers; upper bits read zero
	always_comb begin
		causeView = 32'h0000_0000;
		causeView[wdu_pkg::CAUSE_DOG_BIT] = dogFlag_r;
		statusView = 32'h0000_0000;
		statusView[wdu_pkg::IRQ_WIDTH-1:0] = irqStatus_r;
		maskView = 32'h0000_0000;
		maskView[wdu_pkg::IRQ_WIDTH-1:0] = irqMask_r;
	end

	// Read mux; unmapped addresses read zero
	// Plain decode, no side effects; the status clear lives with the status bits
	always_comb begin
		readMux = 32'h0000_0000;
		case (req.address)
			wdu_pkg::ADDR_CONTROL: begin
				readMux[7:0] = ctrlView;
			end
			wdu_pkg::ADDR_CAUSE: begin
				readMux = causeView;
			end
			wdu_pkg::ADDR_IRQ_STATUS: begin
				readMux = statusView;
			end
			wdu_pkg::ADDR_IRQ_MASK: begin
				readMux = maskView;
			end
			default: begin
				readMux = 32'h0000_0000;
			end
		endcase
	end

	// Read data registered in the wait cycle, stands at the answer edge
	// Held until the next read, so a slow master still sees it
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			avReadData <= 32'h0000_0000;
		end else if (req.read && !ack_r) begin
			avReadData <= readMux;
		end
	end

endmodule : wdu_top

/* File: test/wdu_chk.sv */
`timescale 1ns/1ps
module wdu_chk (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic alwaysOnFuse,
	input wire logic kickInstr,
	input wire logic chipReset,
	input wire logic [3:0] avAddress,
	input wire logic avRead,
	input wire logic avWrite,
	input wire logic [31:0] avWriteData,
	input wire logic [3:0] avByteEnable,
	input wire logic [31:0] avReadData,
	input wire logic avWaitRequest,
	input wire logic dogResetPulse
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// Accepted control read, accepted unlock write
	wire req = avRead | avWrite;
	wire rdCtl = avRead & ~avWaitRequest & (avAddress == 4'h0);
	wire ulWr = avWrite & ~avWaitRequest & (avAddress == 4'h0) & avByteEnable[0]
		& (avWriteData[4:3] == 2'h3);
	logic [3:0] ulAge_r;
	// Age of newest unlock write; saturates so a window that never shuts shows up
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			ulAge_r <= 4'hF;
		else if (ulWr)
			ulAge_r <= 4'h0;
		else if (ulAge_r != 4'hF)
			ulAge_r <= ulAge_r + 4'h1;
	end
	wait_first_a: assert property (req && !$past(req) |-> avWaitRequest)
		else $error("no wait cycle on new request");
	wait_one_a: assert property (avWaitRequest |=> !avWaitRequest)
		else $error("wait longer than one cycle");
	wait_idle_a: assert property (!req |-> !avWaitRequest)
		else $error("wait without request");
	pulse_width_a: assert property ($rose(dogResetPulse) |=> !dogResetPulse)
		else $error("reset pulse not one cycle");
	rsvd_zero_a: assert property (rdCtl |-> avReadData[31:5] == 27'h0)
		else $error("reserved control bits not zero");
	lvl2_enable_a: assert property (rdCtl && alwaysOnFuse && $past(alwaysOnFuse, 6)
		|-> avReadData[3])
		else $error("enable not one at level two");
	kick_quiet_a: assert property (kickInstr |-> ##2 !dogResetPulse [*3])
		else $error("timeout right after kick");
	creset_quiet_a: assert property (chipReset |-> ##2 !dogResetPulse [*3])
		else $error("timeout right after chip reset");
	unlock_age_a: assert property (rdCtl && avReadData[4] |-> ulAge_r < 4'h5)
		else $error("unlock bit held too long");
endmodule : wdu_chk

bind wdu_top wdu_chk u_wdu_chk (.sys_clk(sys_clk), .rst_b(rst_b), .alwaysOnFuse(alwaysOnFuse),
	.kickInstr(kickInstr), .chipReset(chipReset), .avAddress(avAddress), .avRead(avRead),
	.avWrite(avWrite), .avWriteData(avWriteData), .avByteEnable(avByteEnable),
	.avReadData(avReadData), .avWaitRequest(avWaitRequest), .dogResetPulse(dogResetPulse));

/* File: test/wdu_tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module wdu_tb_top;
	logic sys_clk = 1'h0, rst_b = 1'h0, oscClk = 1'h0, oscRun = 1'h0, fuse = 1'h0;
	logic kick = 1'h0, cRst = 1'h0, rd = 1'h0, wr = 1'h0, wreq, pulse, irq, saw;
	logic [3:0] addr = 4'h0, be = 4'hF;
	logic [31:0] wd = 32'h0, rdat, q;
	logic [2:0] s;
	int failures = 0, n_compared = 0, cyc, seed;
	always #2 sys_clk = ~sys_clk;
	// Fast stand-in oscillator, toggling on falling system edges, so sync phase stays fixed
	always #20 if (oscRun) oscClk = ~oscClk;
	always @(posedge sys_clk) if (pulse === 1'h1) saw <= 1'h1;
	wdu_top #(.BASE_CYCLES(4)) u_wdu_top (.sys_clk(sys_clk), .rst_b(rst_b), .oscClk(oscClk),
		.alwaysOnFuse(fuse), .kickInstr(kick), .chipReset(cRst), .avAddress(addr),
		.avRead(rd), .avWrite(wr), .avWriteData(wd), .avByteEnable(be),
		.avReadData(rdat), .avWaitRequest(wreq), .dogResetPulse(pulse), .irq(irq));
	task automatic close_out;
		$display("Compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out
	// Request held up between calls, so back-to-back writes land in the window
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		wr <= w;
		rd <= !w;
		addr <= a;
		wd <= {24'h0, d};
		be <= {3'($urandom), 1'h1};
		do begin
			@(negedge sys_clk);
			n++;
		end while (wreq !== 1'h0 && n < 50);
		if (n >= 50) begin
			failures++;
			close_out();
		end
		@(posedge sys_clk);
		q = rdat;
	endtask : acc
	task automatic idle;
		rd <= 1'h0;
		wr <= 1'h0;
		@(posedge sys_clk);
	endtask : idle
	task automatic strobe(input logic c);
		if (c) cRst <= 1'h1;
		else kick <= 1'h1;
		@(posedge sys_clk);
		cRst <= 1'h0;
		kick <= 1'h0;
		@(posedge sys_clk);
	endtask : strobe
	task automatic wait_pulse(input int lim);
		cyc = 0;
		while (pulse !== 1'h1 && cyc < lim) begin
			@(posedge sys_clk);
			cyc++;
		end
	endtask : wait_pulse
	initial begin
		seed = $urandom(32'h8abf);
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'h1;
		repeat (6) @(posedge sys_clk);
		// Reset state, unmapped read, writes outside the window
		acc(1'h0, 4'h0, 8'h0);
		`CHK("ctl reset", 8'h00, q[7:0])
		acc(1'h0, 4'h2, 8'h0);
		`CHK("unmapped", 32'h0, q)
		acc(1'h1, 4'h0, 8'hEB);
		acc(1'h1, 4'h0, 8'h00);
		acc(1'h0, 4'h0, 8'h0);
		`CHK("ctl locked", 8'h08, q[7:0])
		// Timed disable with random select, then a window left to expire
		s = 3'($urandom);
		acc(1'h1, 4'h0, 8'h18);
		acc(1'h1, 4'h0, {5'h0, s});
		acc(1'h0, 4'h0, 8'h0);
		`CHK("ctl off", {5'h0, s}, q[7:0])
		acc(1'h1, 4'h0, 8'h18);
		acc(1'h0, 4'h0, 8'h0);
		`CHK("unlock open", 1'h1, q[4])
		idle();
		repeat (6) @(posedge sys_clk);
		acc(1'h1, 4'h0, {5'h0, ~s});
		acc(1'h0, 4'h0, 8'h0);
		`CHK("unlock shut", {5'h1, s}, q[7:0])
		idle();
		// No oscillator, no timeout even while enabled
		wait_pulse(300);
		`CHK("osc stopped", 300, cyc)
		$display("test registers done");
		oscRun = 1'h1;
		acc(1'h1, 4'hC, 8'h03);
		for (int i = 0; i < 8; i++) begin
			acc(1'h1, 4'h0, 8'h18);
			acc(1'h1, 4'h0, 8'h08 | i[7:0]);
			idle();
			strobe(1'h0);
			wait_pulse(6000);
			`CHK("period", 1'h1, cyc > (40 << i) - 14 && cyc < (40 << i) + 14)
			repeat (3) @(posedge sys_clk);
			`CHK("irq on", 1'h1, irq)
			acc(1'h0, 4'h4, 8'h0);
			`CHK("flag", 1'h1, q[3])
			acc(1'h1, 4'h4, 8'h00);
			acc(1'h0, 4'h4, 8'h0);
			`CHK("flag clear", 1'h0, q[3])
			acc(1'h0, 4'h8, 8'h0);
			`CHK("status", 2'h3, q[1:0])
			acc(1'h0, 4'h0, 8'h0);
			`CHK("ctl after", 8'h00, q[7:0])
			idle();
			`CHK("irq off", 1'h0, irq)
		end
		$display("test timeouts done");
		// Masked kick event stays silent until unmasked
		acc(1'h1, 4'hC, 8'h00);
		idle();
		strobe(1'h0);
		repeat (3) @(posedge sys_clk);
		`CHK("irq masked", 1'h0, irq)
		acc(1'h1, 4'hC, 8'h02);
		idle();
		repeat (3) @(posedge sys_clk);
		`CHK("irq unmask", 1'h1, irq)
		acc(1'h0, 4'h8, 8'h0);
		`CHK("kick status", 2'h2, q[1:0])
		// Random kicks inside the period keep the dog quiet
		acc(1'h1, 4'h0, 8'h08);
		idle();
		saw <= 1'h0;
		repeat (20) begin
			repeat (5 + $urandom % 20) @(posedge sys_clk);
			strobe(1'h0);
		end
		`CHK("kept alive", 1'h0, saw)
		// Chip reset near the end of a period restarts the count
		repeat (30) @(posedge sys_clk);
		strobe(1'h1);
		acc(1'h1, 4'h0, 8'h08);
		idle();
		wait_pulse(200);
		`CHK("after reset", 1'h1, cyc > 26 && cyc < 54)
		$display("test kicks done");
		// Level two: enable stuck, select change through the window
		fuse <= 1'h1;
		repeat (8) @(posedge sys_clk);
		acc(1'h0, 4'h0, 8'h0);
		`CHK("lvl2 enable", 1'h1, q[3])
		acc(1'h1, 4'h0, 8'h18);
		acc(1'h1, 4'h0, 8'h02);
		acc(1'h1, 4'h0, 8'h00);
		acc(1'h0, 4'h0, 8'h0);
		`CHK("lvl2 select", 8'h0A, q[7:0])
		idle();
		$display("test level two done");
		close_out();
	end
endmodule : wdu_tb_top
